// >>> fcm_host.sv
// Purpose: host controller that drives a NOR flash command register over its pins
// Assumes: flash pins asynchronous to mclk_in; AXI4-Lite slave for software
// Notes:   one flash operation at a time; write CTRL to launch an operation
//
// Functional notes
// - after bad sequences the host issues reset to resume array reads.
// - timeout flag seen high makes host issue reset.
// - buffer-abort flag high makes host issue the abort-reset sequence.
// - autoselect is two unlocks then command, only from read modes.
// - query entry is 98h at 55h from read mode; reset leaves it.
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/100ps

module fcm_host
  import fcm_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              sys_rst_in,
  // axi4-lite write address / data / response
  input  wire logic [7:0]        s_axi_awaddr_in,
  input  wire logic              s_axi_awvalid_in,
  output logic                   s_axi_awready_out,
  input  wire logic [31:0]       s_axi_wdata_in,
  input  wire logic [3:0]        s_axi_wstrb_in,
  input  wire logic              s_axi_wvalid_in,
  output logic                   s_axi_wready_out,
  output logic [1:0]             s_axi_bresp_out,
  output logic                   s_axi_bvalid_out,
  input  wire logic              s_axi_bready_in,
  // axi4-lite read
  input  wire logic [7:0]        s_axi_araddr_in,
  input  wire logic              s_axi_arvalid_in,
  output logic                   s_axi_arready_out,
  output logic [31:0]            s_axi_rdata_out,
  output logic [1:0]             s_axi_rresp_out,
  output logic                   s_axi_rvalid_out,
  input  wire logic              s_axi_rready_in,
  // flash pins
  output logic [ADDR_W-1:0]      flash_addr_out,
  output logic                   flash_ce_n_out,
  output logic                   flash_we_n_out,
  output logic                   flash_oe_n_out,
  output logic [15:0]            flash_dq_out,
  output logic                   flash_dq_oe_out,
  input  wire logic [15:0]       flash_dq_in
);

  // ==========================================================================
  // helpers
  function automatic logic [1:0] op_len(input fcm_op_t op);
    op_len = (op == OP_AUTOSEL || op == OP_ABORT) ? 2'd3 : 2'd1;
  endfunction

  function automatic fcm_cycle_t op_cycle(input fcm_op_t op, input logic [1:0] step,
                                          input logic [31:0] a, input logic [15:0] d);
    fcm_cycle_t c;
    c = '{addr: a, data: d};
    // unlock, unlock, then the mode command
    if (op == OP_AUTOSEL || op == OP_ABORT)
    begin
      case (step)
        2'd0:    c = '{addr: {20'h00000, ADR_UNLOCK1}, data: CMD_UNLOCK1};
        2'd1:    c = '{addr: {20'h00000, ADR_UNLOCK2}, data: CMD_UNLOCK2};
        default: c = '{addr: {20'h00000, ADR_UNLOCK1}, data: (op == OP_AUTOSEL) ? CMD_AUTOSEL : CMD_RESET};
      endcase
    end
    // reset address is don't-care, keep the user's
    else if (op == OP_RESET)
      c.data = CMD_RESET;
    else if (op == OP_QUERY)
      c = '{addr: {20'h00000, ADR_QUERY}, data: CMD_QUERY};
    op_cycle = c;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++)
      old[i*8 +: 8] = be[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    merge = old;
  endfunction

  // ==========================================================================
  // state
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ISSUE  = 3'b001,
    ST_WE_LO  = 3'b010,
    ST_WE_HI  = 3'b011,
    ST_RD     = 3'b100,
    ST_FINISH = 3'b101
  } fcm_state_t;

  fcm_state_t  state_ff;
  fcm_mode_t   mode_ff;
  fcm_op_t     op_ff;
  logic [1:0]  step_ff;
  logic [7:0]  cnt_ff;
  logic [4:0]  ctrl_ff;
  logic [31:0] addr_ff;
  logic [31:0] wdata_ff;
  logic [15:0] rword_ff;
  logic        tmo_ff;
  logic        abt_ff;
  logic        refused_ff;
  logic [15:0] dq_meta_ff;
  logic [15:0] dq_sync_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wd_ff;
  logic [3:0]  wstrb_ff;
  logic        aw_got_ff;
  logic        w_got_ff;

  // ==========================================================================
  // axi decode
  wire         aw_fire  = s_axi_awvalid_in & s_axi_awready_out;
  wire         w_fire   = s_axi_wvalid_in & s_axi_wready_out;
  wire         ar_fire  = s_axi_arvalid_in & s_axi_arready_out;
  wire         wr_do    = aw_got_ff & w_got_ff & ~s_axi_bvalid_out;
  wire         wr_ctrl  = wr_do & (awaddr_ff == REG_CTRL);
  wire         wr_map   = (awaddr_ff == REG_CTRL) | (awaddr_ff == REG_ADDR) | (awaddr_ff == REG_WDATA)
                          | (awaddr_ff == REG_STATUS);
  wire         clr_tmo  = wr_do & (awaddr_ff == REG_STATUS) & wstrb_ff[0] & wd_ff[ST_TMO];
  wire         clr_abt  = wr_do & (awaddr_ff == REG_STATUS) & wstrb_ff[0] & wd_ff[ST_ABT];
  wire         clr_ref  = wr_do & (awaddr_ff == REG_STATUS) & wstrb_ff[0] & wd_ff[ST_REFUSED];
  wire         busy     = (state_ff != ST_IDLE);
  wire [31:0]  ctrl_new = merge({27'h0, ctrl_ff}, wd_ff, wstrb_ff);
  wire fcm_op_t req_op  = fcm_op_t'(ctrl_new[CTRL_OP_LSB +: 3]);
  // autoselect only from read or erase-suspend-read
  // query only while array reads are possible (or from autoselect)
  wire         allowed  = ~busy & ~((req_op == OP_AUTOSEL) & (mode_ff != MODE_READ))
                          & ~((req_op == OP_QUERY) & (mode_ff == MODE_QUERY));
  wire         launch   = wr_ctrl & allowed;
  wire fcm_cycle_t cyc  = op_cycle(op_ff, step_ff, addr_ff, wdata_ff[15:0]);
  wire         last_stp = (step_ff == op_len(op_ff) - 2'd1);
  wire         cnt_end  = (cnt_ff == 8'd1);
  wire [31:0]  status   = {25'h0, refused_ff, abt_ff, tmo_ff, ctrl_ff[CTRL_ESR], mode_ff, busy};
  // timeout seen on a status read asks for reset
  wire         need_rst = ctrl_ff[CTRL_AUTO] & (op_ff == OP_READ) & dq_sync_ff[TIMEOUT_FLAG_BIT];
  // buffer abort seen asks for the abort-reset sequence
  wire         need_abt = ctrl_ff[CTRL_AUTO] & (op_ff == OP_READ) & dq_sync_ff[BUFFER_ABORT_FLAG_BIT];
  wire [31:0]  rd_mux   = (s_axi_araddr_in == REG_CTRL)   ? {27'h0, ctrl_ff} :
                          (s_axi_araddr_in == REG_ADDR)   ? addr_ff :
                          (s_axi_araddr_in == REG_WDATA)  ? wdata_ff :
                          (s_axi_araddr_in == REG_STATUS) ? status :
                          (s_axi_araddr_in == REG_RDATA)  ? {16'h0, rword_ff} : 32'h0;
  wire         rd_map   = (s_axi_araddr_in == REG_CTRL) | (s_axi_araddr_in == REG_ADDR)
                          | (s_axi_araddr_in == REG_WDATA) | (s_axi_araddr_in == REG_STATUS)
                          | (s_axi_araddr_in == REG_RDATA);
  wire         nxt_aw   = (aw_got_ff | aw_fire) & ~wr_do;
  wire         nxt_w    = (w_got_ff | w_fire) & ~wr_do;
  wire         nxt_b    = wr_do | (s_axi_bvalid_out & ~s_axi_bready_in);
  wire         nxt_r    = ar_fire | (s_axi_rvalid_out & ~s_axi_rready_in);

  // ==========================================================================
  // axi slave
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      aw_got_ff         <= 1'b0;
      w_got_ff          <= 1'b0;
      awaddr_ff         <= 8'h00;
      wd_ff             <= 32'h0;
      wstrb_ff          <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= RESP_OKAY;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rresp_out   <= RESP_OKAY;
      s_axi_rdata_out   <= 32'h0;
    end
    else
    begin
      aw_got_ff         <= nxt_aw;
      w_got_ff          <= nxt_w;
      if (aw_fire)
        awaddr_ff <= s_axi_awaddr_in;
      if (w_fire)
      begin
        wd_ff    <= s_axi_wdata_in;
        wstrb_ff <= s_axi_wstrb_in;
      end
      s_axi_awready_out <= ~nxt_aw & ~nxt_b;
      s_axi_wready_out  <= ~nxt_w & ~nxt_b;
      s_axi_bvalid_out  <= nxt_b;
      if (wr_do)
        s_axi_bresp_out <= wr_map ? RESP_OKAY : RESP_SLVERR;
      s_axi_arready_out <= ~nxt_r & ~ar_fire;
      s_axi_rvalid_out  <= nxt_r;
      if (ar_fire)
      begin
        s_axi_rdata_out <= rd_mux;
        s_axi_rresp_out <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // ==========================================================================
  // software registers and sticky flags (set beats clear)
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      ctrl_ff    <= 5'h0;
      addr_ff    <= 32'h0;
      wdata_ff   <= 32'h0;
      tmo_ff     <= 1'b0;
      abt_ff     <= 1'b0;
      refused_ff <= 1'b0;
    end
    else
    begin
      if (wr_ctrl & ~busy)
        ctrl_ff <= ctrl_new[4:0];
      if (wr_do & (awaddr_ff == REG_ADDR) & ~busy)
        addr_ff <= merge(addr_ff, wd_ff, wstrb_ff);
      if (wr_do & (awaddr_ff == REG_WDATA) & ~busy)
        wdata_ff <= merge(wdata_ff, wd_ff, wstrb_ff);
      tmo_ff     <= (state_ff == ST_FINISH && op_ff == OP_READ && dq_sync_ff[TIMEOUT_FLAG_BIT])
                    | (tmo_ff & ~clr_tmo);
      abt_ff     <= (state_ff == ST_FINISH && op_ff == OP_READ && dq_sync_ff[BUFFER_ABORT_FLAG_BIT])
                    | (abt_ff & ~clr_abt);
      refused_ff <= (wr_ctrl & ~allowed) | (refused_ff & ~clr_ref);
    end
  end

  // ==========================================================================
  // pin input synchroniser
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      dq_meta_ff <= 16'h0;
      dq_sync_ff <= 16'h0;
    end
    else
    begin
      dq_meta_ff <= flash_dq_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

  // ==========================================================================
  // flash cycle engine
  always_ff @(posedge mclk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      state_ff        <= ST_IDLE;
      mode_ff         <= MODE_READ;
      op_ff           <= OP_READ;
      step_ff         <= 2'd0;
      cnt_ff          <= 8'd0;
      rword_ff        <= 16'h0;
      flash_addr_out  <= '0;
      flash_ce_n_out  <= 1'b1;
      flash_we_n_out  <= 1'b1;
      flash_oe_n_out  <= 1'b1;
      flash_dq_out    <= 16'h0;
      flash_dq_oe_out <= 1'b0;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
          if (launch)
          begin
            op_ff    <= req_op;
            step_ff  <= 2'd0;
            state_ff <= ST_ISSUE;
          end
        ST_ISSUE:
        begin
          // address set, both strobes fall and write data driven, all in the same cycle
          flash_addr_out <= cyc.addr[ADDR_W-1:0];
          flash_ce_n_out <= 1'b0;
          if (op_ff == OP_READ)
          begin
            flash_oe_n_out <= 1'b0;
            cnt_ff         <= 8'(ACC_CYC);
            state_ff       <= ST_RD;
          end
          else
          begin
            flash_we_n_out  <= 1'b0;
            flash_dq_out    <= cyc.data;
            flash_dq_oe_out <= 1'b1;
            cnt_ff          <= 8'(WP_CYC);
            state_ff        <= ST_WE_LO;
          end
        end
        ST_WE_LO:
        begin
          cnt_ff <= cnt_ff - 8'd1;
          if (cnt_end)
          begin
            // data stays driven past the rising strobe
            flash_we_n_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            cnt_ff         <= 8'(WPH_CYC);
            state_ff       <= ST_WE_HI;
          end
        end
        ST_WE_HI:
        begin
          cnt_ff          <= cnt_ff - 8'd1;
          flash_dq_oe_out <= 1'b0;
          if (cnt_end)
          begin
            step_ff  <= step_ff + 2'd1;
            state_ff <= last_stp ? ST_FINISH : ST_ISSUE;
          end
        end
        ST_RD:
        begin
          cnt_ff <= cnt_ff - 8'd1;
          if (cnt_end)
          begin
            rword_ff       <= dq_sync_ff;
            flash_oe_n_out <= 1'b1;
            flash_ce_n_out <= 1'b1;
            state_ff       <= ST_FINISH;
          end
        end
        ST_FINISH:
        begin
          // reset leaves autoselect; erase-suspend context kept by device
          // any reset returns tracking to read-array
          if (op_ff == OP_RESET || op_ff == OP_ABORT)
            mode_ff <= MODE_READ;
          else if (op_ff == OP_QUERY)
            mode_ff <= MODE_QUERY;
          else if (op_ff == OP_AUTOSEL)
            mode_ff <= MODE_AUTOSEL;
          step_ff <= 2'd0;
          // abort-reset takes priority over plain reset
          if (need_abt)
          begin
            op_ff    <= OP_ABORT;
            state_ff <= ST_ISSUE;
          end
          else if (need_rst)
          begin
            op_ff    <= OP_RESET;
            state_ff <= ST_ISSUE;
          end
          else
            state_ff <= ST_IDLE;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule // fcm_host

// >>> fcm_pkg.sv
// Purpose: shared constants and types for the flash command-mode host controller
// Assumes: 100 MHz mclk_in, x16 flash data path
// Notes:   register map is word aligned on AXI4-Lite
package fcm_pkg;

  // ==========================================================================
  // clock and pin timing
  localparam int CLK_MHZ    = 100;
  localparam int T_WP_NS    = 35;   // write pulse low, least
  localparam int T_WPH_NS   = 20;   // write pulse high, least
  localparam int T_ACC_NS   = 70;   // read access, least wait
  localparam int SYNC_STAGE = 2;
  localparam int WP_CYC     = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int WPH_CYC    = (T_WPH_NS * CLK_MHZ + 999) / 1000;
  localparam int ACC_CYC    = (T_ACC_NS * CLK_MHZ + 999) / 1000 + SYNC_STAGE;

  // ==========================================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  // ctrl fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_ESR    = 3;
  localparam int CTRL_AUTO   = 4;
  // status fields
  localparam int ST_BUSY     = 0;
  localparam int ST_MODE_LSB = 1;
  localparam int ST_ESR      = 3;
  localparam int ST_TMO      = 4;
  localparam int ST_ABT      = 5;
  localparam int ST_REFUSED  = 6;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ==========================================================================
  // flash commands
  localparam logic [15:0] CMD_UNLOCK1  = 16'h00aa;
  localparam logic [15:0] CMD_UNLOCK2  = 16'h0055;
  localparam logic [15:0] CMD_AUTOSEL  = 16'h0090;
  localparam logic [15:0] CMD_RESET    = 16'h00f0;
  localparam logic [15:0] CMD_QUERY    = 16'h0098;
  localparam logic [11:0] ADR_UNLOCK1  = 12'h555;
  localparam logic [11:0] ADR_UNLOCK2  = 12'h2aa;
  localparam logic [11:0] ADR_QUERY    = 12'h055;
  localparam int          TIMEOUT_FLAG_BIT      = 5;
  localparam int          BUFFER_ABORT_FLAG_BIT = 1;

  // ==========================================================================
  // types
  typedef enum logic [2:0] {
    OP_READ    = 3'b000,
    OP_WRITE   = 3'b001,
    OP_RESET   = 3'b010,
    OP_QUERY   = 3'b011,
    OP_AUTOSEL = 3'b100,
    OP_ABORT   = 3'b101
  } fcm_op_t;

  typedef enum logic [1:0] {
    MODE_READ    = 2'b00,
    MODE_QUERY   = 2'b01,
    MODE_AUTOSEL = 2'b10
  } fcm_mode_t;

  typedef struct packed {
    logic [31:0] addr;
    logic [15:0] data;
  } fcm_cycle_t;

endpackage

// >>> fcm_host_asserts.sv
// Purpose: pin and bus checks for the flash command-mode host
// Assumes: one clock, async active-high reset
// Notes:   pulse lengths follow the package timing counts
`timescale 1ns/100ps
module fcm_host_asserts
  import fcm_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  // clock, reset, bus answers
  input wire logic              mclk_in,
  input wire logic              sys_rst_in,
  input wire logic              s_axi_bvalid_out,
  input wire logic              s_axi_bready_in,
  input wire logic [1:0]        s_axi_bresp_out,
  input wire logic              s_axi_rvalid_out,
  input wire logic              s_axi_rready_in,
  input wire logic [31:0]       s_axi_rdata_out,
  // flash pins
  input wire logic [ADDR_W-1:0] flash_addr_out,
  input wire logic              flash_ce_n_out,
  input wire logic              flash_we_n_out,
  input wire logic              flash_oe_n_out,
  input wire logic [15:0]       flash_dq_out,
  input wire logic              flash_dq_oe_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  // ==========================================================================
  // flash write and read cycles
  property p_we_frame; !flash_we_n_out |-> !flash_ce_n_out && flash_oe_n_out && flash_dq_oe_out; endproperty
  a_we_frame: assert property (p_we_frame) else $error("write strobe outside a select");
  property p_we_width; $fell(flash_we_n_out) |-> !flash_we_n_out [*4] ##1 flash_we_n_out [*2]; endproperty
  a_we_width: assert property (p_we_width) else $error("write pulse length wrong");
  // latched on the later fall and the earlier rise, so both must hold
  property p_hold; !flash_we_n_out && $past(!flash_we_n_out) |-> $stable(flash_addr_out) && $stable(flash_dq_out);
  endproperty
  a_hold: assert property (p_hold) else $error("address or data moved in a write pulse");
  property p_oe_frame; !flash_oe_n_out |-> !flash_ce_n_out && flash_we_n_out && !flash_dq_oe_out; endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("read cycle overlaps a write or drive");
  property p_rd_width; $fell(flash_oe_n_out) |-> !flash_oe_n_out [*8] ##1 !flash_oe_n_out ##1 flash_oe_n_out;
  endproperty
  a_rd_width: assert property (p_rd_width) else $error("read cycle length wrong");
  // ==========================================================================
  // command sequences
  // falls are 7 apart: 4 low, 2 high, 1 issue cycle
  property p_unlock; $fell(flash_we_n_out) && flash_dq_out == CMD_UNLOCK1 && flash_addr_out[11:0] == ADR_UNLOCK1
    |-> ##7 ($fell(flash_we_n_out) && flash_dq_out == CMD_UNLOCK2 && flash_addr_out[11:0] == ADR_UNLOCK2)
    ##7 ($fell(flash_we_n_out) && flash_addr_out[11:0] == ADR_UNLOCK1); endproperty
  a_unlock: assert property (p_unlock) else $error("unlock sequence broken");
  property p_query; $fell(flash_we_n_out) && flash_dq_out == CMD_QUERY |-> flash_addr_out[11:0] == ADR_QUERY;
  endproperty
  a_query: assert property (p_query) else $error("query command at wrong address");
  // ==========================================================================
  // bus answers hold until taken
  property p_b_hold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold; s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
endmodule // fcm_host_asserts

bind fcm_host fcm_host_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// >>> fcm_flash_model.sv
// Purpose: behavioural flash command register on the far side of the pins
// Assumes: no program or erase engine, so no suspend state
// Notes:   released data bus shows the inverse of the last word
`timescale 1ns/100ps
module fcm_flash_model
  import fcm_pkg::*;
#(
  parameter int                 ADDR_W     = 24,
  parameter logic [15:0]        WP_PLACE   = 16'h0004,
  parameter logic [ADDR_W-9:0]  PROT_SECT  = 16'h0123,
  parameter logic [15:0]        MAKER_CODE = 16'h005a, // arbitrary value
  parameter logic [15:0]        DEV_CODE   = 16'h22c3  // arbitrary value
)(
  // flash pins
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic              ce_n_in,
  input  wire logic              we_n_in,
  input  wire logic              oe_n_in,
  input  wire logic [15:0]       dq_in,
  output logic [15:0]            dq_out,
  output logic                   dq_oe_out
);
  localparam logic [15:0] QTAB [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0010,
    16'h0002, 16'h0001, 16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0002, 16'h00b5, 16'h00c5,
    WP_PLACE, 16'h0001};
  logic [ADDR_W-1:0] lat_addr;
  logic [15:0]       lat_data;
  logic [15:0]       rd_val;
  logic [15:0]       last_val = 16'h0000;
  logic [1:0]        step     = 2'h0;
  fcm_mode_t         mode     = MODE_READ;
  wire logic         wr_n     = ce_n_in | we_n_in;
  wire logic [7:0]   low_a    = addr_in[7:0];
  wire logic [ADDR_W-9:0] sector_addr = addr_in[ADDR_W-1:8];
  always @(negedge wr_n)
    #1 lat_addr = addr_in;
  // data on the earlier rise; reset mid-sequence clears step
  always @(posedge wr_n)
  begin
    lat_data = dq_in;
    if (lat_data[7:0] == 8'hf0)
      mode = MODE_READ;
    else if (step == 2'h2 && lat_data == CMD_AUTOSEL && lat_addr[11:0] == ADR_UNLOCK1 && mode == MODE_READ)
      mode = MODE_AUTOSEL;
    else if (lat_data == CMD_QUERY && lat_addr[11:0] == ADR_QUERY && mode != MODE_QUERY)
      mode = MODE_QUERY;
    step = (lat_data == CMD_UNLOCK1 && lat_addr[11:0] == ADR_UNLOCK1) ? 2'h1 :
           (step == 2'h1 && lat_data == CMD_UNLOCK2 && lat_addr[11:0] == ADR_UNLOCK2) ? 2'h2 : 2'h0;
  end
  always_comb
    case (mode)
      MODE_QUERY:   rd_val = (low_a >= 8'h40 && low_a <= 8'h50) ? QTAB[low_a - 8'h40] : 16'h0000;
      MODE_AUTOSEL: rd_val = (low_a == 8'h00) ? MAKER_CODE :
                             (low_a inside {8'h01, 8'h0e, 8'h0f}) ? DEV_CODE :
                             (low_a == 8'h02) ? {15'h0000, sector_addr == PROT_SECT} : 16'h0000;
      default:      rd_val = addr_in[15:0];
    endcase
  always @(posedge oe_n_in)
    last_val = rd_val;
  assign dq_oe_out = !ce_n_in && !oe_n_in;
  assign dq_out    = dq_oe_out ? rd_val : ~last_val;
endmodule // fcm_flash_model

// >>> test_fcm_host.sv
// Purpose: self-checking bench for the flash command-mode host
// Assumes: flash model on the pins, AXI4-Lite master tasks here
// Notes:   variant word is set on the model; protected sector is left at the model default
`timescale 1ns/100ps
module test_fcm_host
  import fcm_pkg::*;
;
  localparam int          ADDR_W = 24;
  localparam logic [15:0] WP     = 16'h0005;
  localparam logic [15:0] QEXP [17] = '{16'h0050, 16'h0052, 16'h0049, 16'h0031, 16'h0033, 16'h0010,
    16'h0002, 16'h0001, 16'h0000, 16'h0008, 16'h0000, 16'h0000, 16'h0002, 16'h00b5, 16'h00c5, WP, 16'h0001};
  logic mclk_in = 1'b0, sys_rst_in = 1'b1;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out;
  logic [3:0] s_axi_wstrb_in = 4'hf;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
  logic [ADDR_W-1:0] flash_addr_out;
  logic flash_ce_n_out, flash_we_n_out, flash_oe_n_out, flash_dq_oe_out, mdl_oe;
  logic [15:0] flash_dq_out, mdl_dq, flash_dq_in;
  int fails = 0, checked = 0;
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : mdl_dq;
  always #5 mclk_in = ~mclk_in;
  fcm_host #(.ADDR_W(ADDR_W)) u_dut (.*);
  fcm_flash_model #(.ADDR_W(ADDR_W), .WP_PLACE(WP)) u_flash (.addr_in(flash_addr_out), .ce_n_in(flash_ce_n_out),
    .we_n_in(flash_we_n_out), .oe_n_in(flash_oe_n_out), .dq_in(flash_dq_in), .dq_out(mdl_dq), .dq_oe_out(mdl_oe));
  // ==========================================================================
  // report and bus tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic hang();
    fails++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      n++;
      if (s_axi_awready_out)
        s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out)
        s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1 && n < 64);
    if (n >= 64)
      hang();
    r = s_axi_bresp_out;
    s_axi_bready_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do
    begin
      @(posedge mclk_in);
      n++;
      if (s_axi_arready_out)
        s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1 && n < 64);
    if (n >= 64)
      hang();
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // launch one operation and wait while busy
  task automatic op(input fcm_op_t o, input logic [31:0] a);
    logic [1:0] r;
    logic [31:0] st;
    int n;
    axw(REG_ADDR, a, r);
    axw(REG_CTRL, 32'(o), r);
    n = 0;
    do
    begin
      axr(REG_STATUS, st, r);
      n++;
    end while (st[ST_BUSY] !== 1'b0 && n < 100);
    if (n >= 100)
      hang();
  endtask
  task automatic rd_chk(input logic [31:0] a, input logic [15:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    op(OP_READ, a);
    axr(REG_RDATA, v, r);
    chk(v & 32'h0000ffff, {16'h0000, exp});
  endtask
  task automatic st_chk(input logic [31:0] mask, input logic [31:0] exp);
    logic [31:0] v;
    logic [1:0] r;
    axr(REG_STATUS, v, r);
    chk(v & mask, exp);
  endtask
  task automatic clr();
    logic [1:0] r;
    axw(REG_STATUS, 32'h70, r);
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_boot();
    logic [31:0] v;
    logic [1:0] r;
    st_chk(32'h7f, 32'h0);
    axr(8'h14, v, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    axw(8'h14, 32'h1, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    rd_chk(32'h0c4c, 16'h0c4c);
    rd_chk(32'h0020, 16'h0020);
    st_chk(32'h30, 32'h10);
    rd_chk(32'h0002, 16'h0002);
    st_chk(32'h30, 32'h30);
    op(OP_ABORT, 32'h0);
    clr();
    st_chk(32'h7f, 32'h0);
    $display("test boot and flags done");
  endtask
  task automatic t_query();
    logic [1:0] r;
    op(OP_QUERY, 32'h0);
    st_chk(32'h7, 32'h2);
    for (int i = 0; i < 17; i++)
      rd_chk(32'h40 + i, QEXP[i]);
    op(OP_QUERY, 32'h0);
    st_chk(32'h40, 32'h40);
    axw(REG_WDATA, 32'h00f0, r);
    op(OP_WRITE, 32'h000040);
    rd_chk(32'h0040, 16'h0040);
    op(OP_RESET, 32'habcdef);
    st_chk(32'h7, 32'h0);
    rd_chk(32'h0c4c, 16'h0c4c);
    op(OP_QUERY, 32'h0);
    axw(REG_ADDR, 32'h43, r);
    axw(REG_CTRL, 32'h10, r);
    repeat (60) @(posedge mclk_in);
    st_chk(32'h17, 32'h10);
    clr();
    $display("test query done");
  endtask
  task automatic t_autosel();
    logic [7:0] ids [3] = '{8'h01, 8'h0e, 8'h0f};
    op(OP_AUTOSEL, 32'h0);
    st_chk(32'h7, 32'h4);
    rd_chk(32'h00ab00, 16'h005a);
    for (int i = 0; i < 3; i++)
      rd_chk({24'h0, ids[i]}, 16'h22c3);
    rd_chk(32'h012302, 16'h0001);
    rd_chk(32'h012402, 16'h0000);
    clr();
    op(OP_AUTOSEL, 32'h0);
    st_chk(32'h40, 32'h40);
    op(OP_RESET, 32'h0);
    st_chk(32'h7, 32'h0);
    rd_chk(32'h0c4c, 16'h0c4c);
    $display("test autoselect done");
  endtask
  initial
  begin
    repeat (5) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    t_boot();
    t_query();
    t_autosel();
    complete_run();
  end
endmodule // test_fcm_host
